// File: asc_pkg.sv
// Purpose: Shared constants for the sample buffer and comparator control
// Assumes: One clock at 100 MHz, 32-bit register port, word per register
// Notes: Offsets are byte addresses on the register port
package asc_pkg;
    // Register offsets
    localparam logic [7:0] REG_BUF_CTRL = 8'h00;
    localparam logic [7:0] REG_BUF_SRC = 8'h04;
    localparam logic [7:0] REG_BUF_LEN = 8'h08;
    localparam logic [7:0] REG_BUF_BASE = 8'h0C;
    localparam logic [7:0] REG_BUF_STAT = 8'h10;
    localparam logic [7:0] REG_CMP_CTRL = 8'h14;
    localparam logic [7:0] REG_CMP_STAT = 8'h18;
    // Buffer control bits; start and stop are write-only commands
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_WRAP = 2;
    localparam int CTRL_RANGE = 3;
    localparam int CTRL_EV_LO = 4;
    // Event enable order inside the three-bit field
    localparam int EV_OVF = 0;
    localparam int EV_FULL = 1;
    localparam int EV_HALF = 2;
    // Status bit positions, write one to clear the sticky events
    localparam int STAT_RUN = 16;
    localparam int STAT_HALF = 17;
    localparam int STAT_FULL = 18;
    localparam int STAT_OVF = 19;
    localparam int STAT_ERR = 20;
    // Source bitmap: bits 0..5 external channels
    localparam int SRC_TEMPERATURE = 6;
    localparam int SRC_SUPPLY = 7;
    // Input range codes
    localparam logic RANGE_SINGLE_REF = 1'b0;
    localparam logic RANGE_DOUBLE_REF = 1'b1;
    // Buffer length limits and position shown once full without wrap
    localparam int LEN_W = 11;
    localparam logic [10:0] POS_FULL_NOWRAP = 11'h7FF;
    // Comparator control bit positions
    localparam int CMP_EN = 0;
    localparam int CMP_SEL_LO = 1;
    localparam int CMP_HYST_LO = 3;
    localparam int CMP_LP = 5;
    localparam int CMP_INT_EN = 6;
    localparam int CMP_INT_RISE = 7;
    localparam int CMP_WAKE_EN = 8;
    localparam int CMP_WAKE_RISE = 9;
    localparam int CMP_CFG_W = 10;
    localparam logic [9:0] CMP_CFG_RST = 10'h000;
    // Input and reference pairings
    localparam logic [1:0] SEL_POS_VS_NEG = 2'h0;
    localparam logic [1:0] SEL_POS_VS_INTERNAL_REF = 2'h1;
    localparam logic [1:0] SEL_NEG_VS_POS = 2'h2;
    localparam logic [1:0] SEL_NEG_VS_INTERNAL_REF = 2'h3;
    // Hysteresis codes: 0, 10, 20, 40 mV
    localparam logic [1:0] HYST_NONE = 2'h0;
    localparam logic [1:0] HYST_SMALL = 2'h1;
    localparam logic [1:0] HYST_MEDIUM = 2'h2;
    localparam logic [1:0] HYST_LARGE = 2'h3;
    // Sample buffer sequencer states
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_WAIT = 5'b00010,
        S_SEL = 5'b00100,
        S_CONV = 5'b01000,
        S_FULL = 5'b10000
    } asc_state_t;
endpackage : asc_pkg

// File: asc_cmp.sv
// Purpose: Comparator control, power mode, interrupt and wake edges
// Assumes: Comparator output arrives asynchronously and is synchronised
// Notes: Hysteresis is applied in the analogue core; only its code leaves
`timescale 1ns/100ps
`default_nettype none
module asc_cmp (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [asc_pkg::CMP_CFG_W-1:0] cfg,
    input wire logic cmp_raw,
    input wire logic sleep_active,
    input wire logic wake_clr,
    output logic cmp_power_en,
    output logic cmp_low_power,
    output logic [1:0] cmp_sel,
    output logic [1:0] cmp_hyst,
    output logic cmp_level,
    output logic cmp_irq,
    output logic cmp_wake,
    output logic wake_flag
);
    import asc_pkg::*;

    // All state of the comparator control
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pwr;
        logic lp;
        logic [1:0] sel;
        logic [1:0] hyst;
        logic irq;
        logic wake;
        logic wflag;
    } asc_cmp_t;

    asc_cmp_t q_ff;
    asc_cmp_t nxt_q;
    logic rise; // Input just went above reference
    logic fall; // Input just went below reference
    logic pins; // Both external pins in use

    // Next-state logic
    always_comb begin
        nxt_q = q_ff;
        // Two-flop synchroniser, s1 feeds only s2
        nxt_q.s1 = cmp_raw;
        nxt_q.s2 = q_ff.s1;
        nxt_q.prev = q_ff.s2;
        rise = q_ff.s2 & ~q_ff.prev;
        fall = ~q_ff.s2 & q_ff.prev;
        // Disable turns the core off whatever else is set
        nxt_q.pwr = cfg[CMP_EN];
        // Standard power unless software asks for low power
        // Sleep forces low power while enabled, whatever the low-power bit
        nxt_q.lp = cfg[CMP_EN] & (cfg[CMP_LP] | sleep_active);
        nxt_q.sel = cfg[CMP_SEL_LO +: 2];
        nxt_q.hyst = cfg[CMP_HYST_LO +: 2];
        // Interrupt on the configured edge only
        nxt_q.irq = q_ff.pwr & cfg[CMP_INT_EN]
            & (cfg[CMP_INT_RISE] ? rise : fall);
        // Wake needs both pins; internal reference never wakes
        pins = (q_ff.sel == SEL_POS_VS_NEG) | (q_ff.sel == SEL_NEG_VS_POS);
        nxt_q.wake = q_ff.pwr & pins & cfg[CMP_WAKE_EN]
            & (cfg[CMP_WAKE_RISE] ? rise : fall);
        // Wake flag clears on read, a new wake wins over the clear
        nxt_q.wflag = (q_ff.wflag & ~wake_clr) | nxt_q.wake;
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign cmp_power_en = q_ff.pwr;
    assign cmp_low_power = q_ff.lp;
    assign cmp_sel = q_ff.sel;
    assign cmp_hyst = q_ff.hyst;
    assign cmp_level = q_ff.s2;
    assign cmp_irq = q_ff.irq;
    assign cmp_wake = q_ff.wake;
    assign wake_flag = q_ff.wflag;

    a_sleep_low_power: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleep_active && cfg[CMP_EN]) |=> cmp_low_power)
        else $error("sleep did not force low power");

    a_wake_pins_only: assert property (
        @(posedge clk) disable iff (sys_rst)
        cmp_wake |-> ($past(cmp_sel) == SEL_POS_VS_NEG
            || $past(cmp_sel) == SEL_NEG_VS_POS))
        else $error("wake raised with internal reference");

    a_off_silent: assert property (
        @(posedge clk) disable iff (sys_rst)
        // Pulses lag the power flop by a cycle, so both must be off first
        (!cfg[CMP_EN] && !cmp_power_en)
            |=> (!cmp_power_en && !cmp_irq && !cmp_wake))
        else $error("disabled comparator still active");

    a_irq_edge: assert property (
        @(posedge clk) disable iff (sys_rst)
        cmp_irq |-> ($past(cmp_level) != $past(cmp_level, 2)))
        else $error("interrupt without an edge");
endmodule : asc_cmp
`default_nettype wire

// File: asc_top.sv
// Purpose: Timer-paced sample buffer writer and comparator control
// Assumes: Converter, timer and RAM port run on clk; comparator is async
// Notes: Registers on a plain strobe port, read data one cycle later
`timescale 1ns/100ps
`default_nettype none
module asc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic apt_trigger,
    input wire logic sleep_active,
    output logic adc_start,
    output logic [2:0] adc_chan,
    output logic adc_range_double,
    input wire logic adc_done,
    input wire logic [9:0] adc_result,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [15:0] ram_wdata,
    output logic buf_half_evt,
    output logic buf_full_evt,
    output logic buf_ovf_evt,
    input wire logic cmp_raw,
    output logic cmp_power_en,
    output logic cmp_low_power,
    output logic [1:0] cmp_sel,
    output logic [1:0] cmp_hyst,
    output logic cmp_irq,
    output logic cmp_wake
);
    import asc_pkg::*;

    // All state of the sample buffer path and register file
    typedef struct packed {
        asc_state_t st;
        logic wrap;
        logic rng;
        logic [2:0] ev_en;
        logic [7:0] src;
        logic [10:0] len;
        logic [15:0] base;
        logic [9:0] ccfg;
        logic half_f;
        logic full_f;
        logic ovf_f;
        logic err_f;
        logic [7:0] pend;
        logic [2:0] chan;
        logic [10:0] pos;
        logic adc_go;
        logic we;
        logic [15:0] waddr;
        logic [15:0] wdat;
        logic [2:0] evt;
        logic [31:0] rdata;
    } asc_top_t;

    asc_top_t q_ff;
    asc_top_t nxt_q;
    logic [10:0] pos_inc; // Position after the current write
    logic cmp_level; // Synchronised comparator output
    logic wake_flag; // Sticky wake status
    logic wake_clr; // Status read clears the wake flag

    // Lowest pending source, which gives the fixed conversion order
    function automatic logic [2:0] asc_low_idx(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : asc_low_idx

    assign wake_clr = bus_rd && (bus_addr == REG_CMP_STAT);

    // Next-state logic: clears first, then sequencer, then commands
    always_comb begin
        nxt_q = q_ff;
        nxt_q.adc_go = 1'b0;
        nxt_q.we = 1'b0;
        nxt_q.evt = 3'h0;
        nxt_q.rdata = 32'h0000_0000;
        pos_inc = q_ff.pos + 11'h001;
        // Write one to clear; sequencer sets below so a set wins
        if (bus_wr && bus_addr == REG_BUF_STAT) begin
            nxt_q.half_f = q_ff.half_f & ~bus_wdata[STAT_HALF];
            nxt_q.full_f = q_ff.full_f & ~bus_wdata[STAT_FULL];
            nxt_q.ovf_f = q_ff.ovf_f & ~bus_wdata[STAT_OVF];
            nxt_q.err_f = q_ff.err_f & ~bus_wdata[STAT_ERR];
        end
        case (q_ff.st)
            // Armed: a timer trigger snapshots the source bitmap
            S_WAIT: begin
                if (apt_trigger) begin
                    nxt_q.pend = q_ff.src;
                    nxt_q.st = S_SEL;
                end
            end
            // Start the lowest pending source next
            S_SEL: begin
                if (q_ff.pend == 8'h00) begin
                    nxt_q.st = S_WAIT;
                end else begin
                    nxt_q.chan = asc_low_idx(q_ff.pend);
                    nxt_q.pend = q_ff.pend & (q_ff.pend - 8'h01);
                    nxt_q.adc_go = 1'b1;
                    nxt_q.st = S_CONV;
                end
            end
            // Result goes straight to RAM, no processor step
            S_CONV: begin
                if (adc_done) begin
                    nxt_q.we = 1'b1;
                    nxt_q.waddr = q_ff.base + {5'h00, q_ff.pos};
                    nxt_q.wdat = {6'h00, adc_result};
                    // Half-full when position first reaches len/2
                    if (pos_inc == (q_ff.len >> 1) && q_ff.ev_en[EV_HALF]) begin
                        nxt_q.evt[EV_HALF] = 1'b1;
                        nxt_q.half_f = 1'b1;
                    end
                    if (pos_inc == q_ff.len) begin
                        // Last location written
                        if (q_ff.ev_en[EV_FULL]) begin
                            nxt_q.evt[EV_FULL] = 1'b1;
                            nxt_q.full_f = 1'b1;
                        end
                        if (q_ff.wrap) begin
                            nxt_q.pos = 11'h000;
                            nxt_q.st = S_SEL;
                        end else begin
                            nxt_q.pos = POS_FULL_NOWRAP;
                            nxt_q.st = S_FULL;
                        end
                    end else begin
                        nxt_q.pos = pos_inc;
                        nxt_q.st = S_SEL;
                    end
                end
            end
            // Full without wrap: a further trigger is dropped
            S_FULL: begin
                if (apt_trigger && q_ff.ev_en[EV_OVF]) begin
                    nxt_q.evt[EV_OVF] = 1'b1;
                    nxt_q.ovf_f = 1'b1;
                end
            end
            default: begin
                nxt_q.st = S_IDLE;
            end
        endcase
        // Register writes; commands override the sequencer
        if (bus_wr) begin
            if (bus_addr == REG_BUF_CTRL) begin
                nxt_q.wrap = bus_wdata[CTRL_WRAP];
                nxt_q.rng = bus_wdata[CTRL_RANGE];
                nxt_q.ev_en = bus_wdata[CTRL_EV_LO +: 3];
                if (bus_wdata[CTRL_STOP]) begin
                    nxt_q.st = S_IDLE;
                    nxt_q.pend = 8'h00;
                end else if (bus_wdata[CTRL_START]) begin
                    // Refuse zero length or no event enabled
                    if (q_ff.len == 11'h000
                            || bus_wdata[CTRL_EV_LO +: 3] == 3'h0) begin
                        nxt_q.err_f = 1'b1;
                        nxt_q.st = S_IDLE;
                    end else begin
                        nxt_q.st = S_WAIT;
                        nxt_q.pos = 11'h000;
                        nxt_q.pend = 8'h00;
                    end
                end
            end else if (bus_addr == REG_BUF_SRC) begin
                nxt_q.src = bus_wdata[7:0];
            end else if (bus_addr == REG_BUF_LEN) begin
                // Only 11 bits kept, so 2047 is the most
                nxt_q.len = bus_wdata[LEN_W-1:0];
            end else if (bus_addr == REG_BUF_BASE) begin
                nxt_q.base = bus_wdata[15:0];
            end else if (bus_addr == REG_CMP_CTRL) begin
                nxt_q.ccfg = bus_wdata[CMP_CFG_W-1:0];
            end
        end
        // Register reads, unmapped addresses read zero
        if (bus_rd) begin
            if (bus_addr == REG_BUF_CTRL) begin
                nxt_q.rdata[CTRL_WRAP] = q_ff.wrap;
                nxt_q.rdata[CTRL_RANGE] = q_ff.rng;
                nxt_q.rdata[CTRL_EV_LO +: 3] = q_ff.ev_en;
            end else if (bus_addr == REG_BUF_SRC) begin
                nxt_q.rdata[7:0] = q_ff.src;
            end else if (bus_addr == REG_BUF_LEN) begin
                nxt_q.rdata[LEN_W-1:0] = q_ff.len;
            end else if (bus_addr == REG_BUF_BASE) begin
                nxt_q.rdata[15:0] = q_ff.base;
            end else if (bus_addr == REG_BUF_STAT) begin
                nxt_q.rdata[LEN_W-1:0] = q_ff.pos;
                nxt_q.rdata[STAT_RUN] = (q_ff.st != S_IDLE);
                nxt_q.rdata[STAT_HALF] = q_ff.half_f;
                nxt_q.rdata[STAT_FULL] = q_ff.full_f;
                nxt_q.rdata[STAT_OVF] = q_ff.ovf_f;
                nxt_q.rdata[STAT_ERR] = q_ff.err_f;
            end else if (bus_addr == REG_CMP_CTRL) begin
                nxt_q.rdata[CMP_CFG_W-1:0] = q_ff.ccfg;
            end else if (bus_addr == REG_CMP_STAT) begin
                nxt_q.rdata[0] = cmp_level;
                nxt_q.rdata[1] = wake_flag;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_ff <= '{st: S_IDLE, ccfg: CMP_CFG_RST, default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Comparator control
    asc_cmp u_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg(q_ff.ccfg),
        .cmp_raw(cmp_raw),
        .sleep_active(sleep_active),
        .wake_clr(wake_clr),
        .cmp_power_en(cmp_power_en),
        .cmp_low_power(cmp_low_power),
        .cmp_sel(cmp_sel),
        .cmp_hyst(cmp_hyst),
        .cmp_level(cmp_level),
        .cmp_irq(cmp_irq),
        .cmp_wake(cmp_wake),
        .wake_flag(wake_flag)
    );

    // Outputs straight from the state register
    assign bus_rdata = q_ff.rdata;
    assign adc_start = q_ff.adc_go;
    assign adc_chan = q_ff.chan;
    assign adc_range_double = q_ff.rng;
    assign ram_we = q_ff.we;
    assign ram_addr = q_ff.waddr;
    assign ram_wdata = q_ff.wdat;
    assign buf_half_evt = q_ff.evt[EV_HALF];
    assign buf_full_evt = q_ff.evt[EV_FULL];
    assign buf_ovf_evt = q_ff.evt[EV_OVF];

    a_conv_order: assert property (
        @(posedge clk) disable iff (sys_rst)
        adc_start |-> ((q_ff.pend & ((8'h01 << adc_chan) - 8'h01)) == 8'h00))
        else $error("source converted out of order");

    a_full_halts: assert property (
        @(posedge clk) disable iff (sys_rst)
        (q_ff.st == S_FULL && !bus_wr) |=> (!adc_start && !ram_we))
        else $error("conversion after buffer full");

    a_full_pos: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(q_ff.st == S_FULL) |-> (q_ff.pos == POS_FULL_NOWRAP))
        else $error("full position is not 2047");

    a_wrap_back: assert property (
        @(posedge clk) disable iff (sys_rst)
        (q_ff.st == S_CONV && adc_done && q_ff.wrap && !bus_wr
            && pos_inc == q_ff.len) |=> (q_ff.pos == 11'h000 && ram_we))
        else $error("wrap did not return to start");

    a_word_store: assert property (
        @(posedge clk) disable iff (sys_rst)
        ram_we |-> (ram_wdata == {6'h00, $past(adc_result)}))
        else $error("stored word differs from result");

    a_ovf_drop: assert property (
        @(posedge clk) disable iff (sys_rst)
        (q_ff.st == S_FULL && apt_trigger && q_ff.ev_en[EV_OVF] && !bus_wr)
            |=> (buf_ovf_evt && !ram_we))
        else $error("overflow not raised or sample written");

    a_evt_gated: assert property (
        @(posedge clk) disable iff (sys_rst)
        (buf_full_evt |-> $past(q_ff.ev_en[EV_FULL]))
            and (buf_half_evt |-> $past(q_ff.ev_en[EV_HALF])))
        else $error("event raised while disabled");

    a_bad_start: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_wr && bus_addr == REG_BUF_CTRL && bus_wdata[CTRL_START]
            && !bus_wdata[CTRL_STOP] && q_ff.len == 11'h000)
            |=> (q_ff.st == S_IDLE && q_ff.err_f))
        else $error("zero length start accepted");
endmodule : asc_top
`default_nettype wire

// File: asc_adc_model.sv
// Purpose: Converter core stand-in answering each start with a result
// Assumes: One conversion at a time, result valid only beside done
// Notes: Outside done the result shows the inverse of the last one
`timescale 1ns/100ps
`default_nettype none
module asc_adc_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic adc_start,
    input wire logic [2:0] adc_chan,
    output logic adc_done,
    output logic [9:0] adc_result
);
    logic [3:0] cnt; // Cycles left in the conversion
    logic [9:0] last; // Last result, inverted while idle
    // Latency 2 or 6 cycles; the channel sits in the top result bits
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 4'h0;
            last <= 10'h000;
            adc_done <= 1'b0;
            adc_result <= 10'h3FF;
        end else begin
            adc_done <= 1'b0;
            adc_result <= ~last;
            if (adc_start) begin
                cnt <= slow ? 4'h6 : 4'h2;
                last <= {adc_chan, 7'h2A};
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                if (cnt == 4'h1) begin
                    adc_done <= 1'b1;
                    adc_result <= last;
                end
            end
        end
    end
endmodule : asc_adc_model
`default_nettype wire

// File: test_adc_sample_buffer_and_comparator_ctrl.sv
// Purpose: Register-driven tests of the sample buffer and comparator
// Assumes: Bus strobes and pins change by NBA right after rising edges
// Notes: Writes and events are counted by a monitor on every rising edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end end
module test_adc_sample_buffer_and_comparator_ctrl;
    import asc_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000, bus_rdata, r;
    logic apt_trigger = 1'b0, sleep_active = 1'b0, cmp_raw = 1'b0;
    logic slow = 1'b0, adc_start, adc_done, adc_range_double, ram_we;
    logic [2:0] adc_chan;
    logic [9:0] adc_result;
    logic [15:0] ram_addr, ram_wdata;
    logic buf_half_evt, buf_full_evt, buf_ovf_evt, cmp_power_en;
    logic cmp_low_power, cmp_irq, cmp_wake;
    logic [1:0] cmp_sel, cmp_hyst;
    logic [31:0] wq[$]; // Captured RAM writes: address, data
    int mismatches = 0, check_count = 0, n_half, n_full, n_ovf, n_irq, n_wake;
    asc_top dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .apt_trigger(apt_trigger),
        .sleep_active(sleep_active), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_range_double(adc_range_double),
        .adc_done(adc_done), .adc_result(adc_result), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .buf_half_evt(buf_half_evt), .buf_full_evt(buf_full_evt),
        .buf_ovf_evt(buf_ovf_evt), .cmp_raw(cmp_raw),
        .cmp_power_en(cmp_power_en), .cmp_low_power(cmp_low_power),
        .cmp_sel(cmp_sel), .cmp_hyst(cmp_hyst), .cmp_irq(cmp_irq),
        .cmp_wake(cmp_wake));
    asc_adc_model adc (.clk(clk), .sys_rst(sys_rst), .slow(slow),
        .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
        .adc_result(adc_result));
    always #5 clk = ~clk;
    // Monitor: RAM writes and one-cycle event pulses
    always @(posedge clk) begin
        if (ram_we === 1'b1) wq.push_back({ram_addr, ram_wdata});
        n_half += (buf_half_evt === 1'b1);
        n_full += (buf_full_evt === 1'b1);
        n_ovf += (buf_ovf_evt === 1'b1);
        n_irq += (cmp_irq === 1'b1);
        n_wake += (cmp_wake === 1'b1);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
        @(posedge clk) bus_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) {bus_rd, bus_addr} <= {1'b1, a};
        @(posedge clk) bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic trig();
        @(posedge clk) apt_trigger <= 1'b1;
        @(posedge clk) apt_trigger <= 1'b0;
    endtask : trig
    // Bounded wait for n writes, then let trailing pulses land
    task automatic wait_w(input int n);
        for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask : wait_w
    task automatic cmp_edge(input logic v);
        @(posedge clk) cmp_raw <= v;
        repeat (8) @(posedge clk);
    endtask : cmp_edge
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(REG_BUF_STAT, r);
        `CHK(r, 32'h0000_0000)
        // Refused starts: zero length, then no event enabled
        wr(REG_BUF_CTRL, 32'h0000_0071);
        rd(REG_BUF_STAT, r);
        `CHK(r[STAT_ERR +: 2'd2], 2'b01)
        wr(REG_BUF_STAT, 32'h0010_0000);
        wr(REG_BUF_LEN, 32'h0000_0003);
        wr(REG_BUF_CTRL, 32'h0000_0001);
        rd(REG_BUF_STAT, r);
        `CHK(r[STAT_ERR], 1'b1)
        $display("test refused starts done");
        // Linear run: two sources, length 3, double range
        n_half = 0; n_full = 0; n_ovf = 0;
        wr(REG_BUF_STAT, 32'h0010_0000);
        wr(REG_BUF_SRC, 32'h0000_0081);
        wr(REG_BUF_BASE, 32'h0000_0100);
        wr(REG_BUF_CTRL, 32'h0000_0079);
        trig();
        wait_w(2);
        `CHK(adc_range_double, 1'b1)
        trig();
        wait_w(3);
        trig();
        wait_w(4);
        `CHK(wq.size(), 3)
        for (int i = 0; i < 3; i++)
            `CHK(wq[i], {16'h0100 + 16'(i), 6'h00, i == 1 ? 3'h7 : 3'h0,
                7'h2A})
        `CHK({n_half, n_full, n_ovf}, {32'd1, 32'd1, 32'd1})
        rd(REG_BUF_STAT, r);
        `CHK(r[10:0], POS_FULL_NOWRAP)
        `CHK(r[STAT_OVF:STAT_HALF], 3'b111)
        $display("test linear run done");
        // Wrapping run, slow converter, stopped by command
        wr(REG_BUF_CTRL, 32'h0000_0002);
        wq.delete();
        n_half = 0; n_full = 0; slow <= 1'b1;
        wr(REG_BUF_SRC, 32'h0000_0040);
        wr(REG_BUF_LEN, 32'h0000_0002);
        wr(REG_BUF_BASE, 32'h0000_0200);
        wr(REG_BUF_CTRL, 32'h0000_0065);
        trig();
        wait_w(1);
        `CHK(adc_range_double, 1'b0)
        trig();
        wait_w(2);
        rd(REG_BUF_STAT, r);
        `CHK(r[10:0], 11'h000)
        trig();
        wait_w(3);
        `CHK(wq[2], 32'h0200_0000 | 32'h0000_032A)
        `CHK({n_half, n_full}, {32'd2, 32'd1})
        wr(REG_BUF_CTRL, 32'h0000_0002);
        rd(REG_BUF_STAT, r);
        `CHK(r[STAT_RUN], 1'b0)
        trig();
        wait_w(4);
        `CHK(wq.size(), 3)
        $display("test wrap run done");
        // Comparator pairings, hysteresis and power mode
        for (int s = 0; s < 4; s++) begin
            wr(REG_CMP_CTRL, 32'(1 | (s << 1) | ((3 - s) << 3)));
            repeat (3) @(posedge clk);
            `CHK({cmp_sel, cmp_hyst}, {2'(s), 2'(3 - s)})
            `CHK({cmp_power_en, cmp_low_power}, 2'b10)
        end
        wr(REG_CMP_CTRL, 32'h0000_0021);
        repeat (3) @(posedge clk);
        `CHK(cmp_low_power, 1'b1)
        wr(REG_CMP_CTRL, 32'h0000_0001);
        sleep_active <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(cmp_low_power, 1'b1)
        sleep_active <= 1'b0;
        // Rising interrupt and wake; pins pairing, then internal reference
        n_irq = 0; n_wake = 0;
        wr(REG_CMP_CTRL, 32'h0000_03C1);
        cmp_edge(1'b1);
        cmp_edge(1'b0);
        `CHK({n_irq, n_wake}, {32'd1, 32'd1})
        // Wake flag is set, then cleared by the read itself
        rd(REG_CMP_STAT, r);
        `CHK(r[1:0], 2'b10)
        rd(REG_CMP_STAT, r);
        `CHK(r[1:0], 2'b00)
        // Falling edge selected for both interrupt and wake
        wr(REG_CMP_CTRL, 32'h0000_0141);
        cmp_edge(1'b1);
        cmp_edge(1'b0);
        `CHK({n_irq, n_wake}, {32'd2, 32'd2})
        wr(REG_CMP_CTRL, 32'h0000_03C3);
        cmp_edge(1'b1);
        cmp_edge(1'b0);
        `CHK({n_irq, n_wake}, {32'd3, 32'd2})
        wr(REG_CMP_CTRL, 32'h0000_03C0);
        cmp_edge(1'b1);
        `CHK({cmp_power_en, n_irq, n_wake}, {1'b0, 32'd3, 32'd2})
        $display("test comparator done");
        give_verdict();
    end
endmodule : test_adc_sample_buffer_and_comparator_ctrl
`undef CHK
`default_nettype wire
